// *** logic/quad_dac_regs.vh ***
// Constants of the quad converter control logic.
`ifndef QUAD_DAC_REGS_VH
`define QUAD_DAC_REGS_VH
`define CMD_WR_INPUT      4'h0
`define CMD_UPD_DAC       4'h1
`define CMD_WR_UPD_ALL    4'h2
`define CMD_WR_UPD_ONE    4'h3
`define CMD_POWER         4'h4
`define CMD_CLEAR_CODE    4'h5
`define CMD_OVERRIDE      4'h6
`define CMD_SOFT_RESET    4'h7
`define ADDR_ALL          4'hF
`define FRAME_BITS        6'h20
`define POR_WAIT          2'h2
`define CMD_MSB           27
`define ADDR_MSB          23
`define DATA_MSB          19
`define PWR_MODE_MSB      9
`define CODE_ZERO         16'h0000
`define CODE_MID          16'h8000
`define CODE_FULL         16'hFFFF
`define CLEAR_SEL_RESET   2'h0
`define OVERRIDE_RESET    4'h0
`define PWR_NORMAL        2'h0
`define PWR_1K            2'h1
`define PWR_100K          2'h2
`define PWR_TRISTATE      2'h3
`endif

// *** logic/pin_sync.v ***
// Two-flop synchroniser with edge detection for the serial pins.
`timescale 1ns/1ns
module pin_sync (
	clk_sys,
	resetn,
	pin_in,
	level,
	rise,
	fall
);
	parameter RESET_VAL = 1'b1;
	input  wire clk_sys;
	input  wire resetn;
	input  wire pin_in;
	output wire level;
	output wire rise;
	output wire fall;

	reg meta_r;
	reg sync_r;
	reg prev_r;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
			prev_r <= RESET_VAL;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign rise  = sync_r & ~prev_r;
	assign fall  = ~sync_r & prev_r;
endmodule // pin_sync

// *** logic/quad_dac_control_logic.v ***
// Control logic of a quad converter: serial frame decode, registers and strobes.
//
// Contract
// - At power-up all channels go to zero scale, or midscale when select is high.
// - Outputs hold the power-up level until the first valid complete frame or clear strobe falling edge.
// - Command 0111 returns converter registers to the power-up code.
// - Strobe edges are ignored while power-on reset runs.
// - Command 0100 takes power mode from bits 9 and 8.
// - Bits 3 to 0 select channels D to A for the power mode.
// - A powered-down output connects to the chosen load or floats.
// - Power-down keeps converter codes; writes still land while down.
// - Clear strobe falling loads input and converter registers with the clear code.
// - Command 0101 stores clear selection: zero, mid, full, or no operation.
// - Clear selection resets to zero code.
// - Cleared state ends on the 32nd falling edge of the next frame.
// - A clear during a frame aborts that frame.
// - Synchronous update copies data on the 32nd edge when the update strobe is low.
// - Otherwise writes reach input registers; a low update pulse transfers them.
// - Command 0010 writes the addressed input register then updates all channels.
// - Command 0110 loads the four-bit update override register.
// - Override bits reset to zero; zero means the strobe governs the channel.
// - An override bit of one updates the channel as if the strobe were low.
// - Frames are 32 bits MSB first; execution on the 32nd falling shift edge.
// - Frame sync rising before 32 edges voids the frame entirely.
`timescale 1ns/1ns
`include "quad_dac_regs.vh"
module quad_dac_control_logic (
	clk_sys,
	resetn,
	por_level_sel,
	frame_sync_n,
	shift_clk,
	serial_data,
	load_update_strobe_n,
	clear_strobe_n,
	dac_code_a,
	dac_code_b,
	dac_code_c,
	dac_code_d,
	power_mode,
	amp_connect,
	load_1k_en,
	load_100k_en,
	clear_active,
	por_busy
);
	input  wire        clk_sys;
	input  wire        resetn;
	input  wire        por_level_sel;
	input  wire        frame_sync_n;
	input  wire        shift_clk;
	input  wire        serial_data;
	input  wire        load_update_strobe_n;
	input  wire        clear_strobe_n;
	output wire [15:0] dac_code_a;
	output wire [15:0] dac_code_b;
	output wire [15:0] dac_code_c;
	output wire [15:0] dac_code_d;
	output wire [7:0]  power_mode;
	output reg  [3:0]  amp_connect;
	output reg  [3:0]  load_1k_en;
	output reg  [3:0]  load_100k_en;
	output wire        clear_active;
	output wire        por_busy;

	localparam ST_POR  = 2'h0;
	localparam ST_IDLE = 2'h1;
	localparam ST_RUN  = 2'h2;

	////////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	wire sync_lvl;
	wire sync_rise;
	wire sync_fall;
	wire sclk_fall;
	wire din_lvl;
	wire load_update_strobe_n_lvl;
	wire load_update_strobe_n_fall;
	wire clr_fall;
	wire por_lvl;

	pin_sync #(.RESET_VAL(1'b1)) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pin_in  (frame_sync_n),
		.level   (sync_lvl),
		.rise    (sync_rise),
		.fall    (sync_fall)
	);
	// The shift clock idles high, so its synchroniser resets high to avoid a false edge.
	pin_sync #(.RESET_VAL(1'b1)) u_sclk (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pin_in  (shift_clk),
		.level   (),
		.rise    (),
		.fall    (sclk_fall)
	);
	pin_sync #(.RESET_VAL(1'b0)) u_din (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pin_in  (serial_data),
		.level   (din_lvl),
		.rise    (),
		.fall    ()
	);
	pin_sync #(.RESET_VAL(1'b1)) u_load_update_strobe_n (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pin_in  (load_update_strobe_n),
		.level   (load_update_strobe_n_lvl),
		.rise    (),
		.fall    (load_update_strobe_n_fall)
	);
	pin_sync #(.RESET_VAL(1'b1)) u_clr (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pin_in  (clear_strobe_n),
		.level   (),
		.rise    (),
		.fall    (clr_fall)
	);
	pin_sync #(.RESET_VAL(1'b0)) u_por (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pin_in  (por_level_sel),
		.level   (por_lvl),
		.rise    (),
		.fall    ()
	);

	////////////////////////////////////////////////////////////////////////////////////
	// Helper functions.
	function [15:0] clear_code;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    clear_code = `CODE_ZERO;
				2'h1:    clear_code = `CODE_MID;
				default: clear_code = `CODE_FULL;
			endcase
		end
	endfunction

	// Addresses other than A to D and all-channels select nothing.
	function [3:0] chan_mask;
		input [3:0] addr;
		begin
			if (addr == `ADDR_ALL)
				chan_mask = 4'hF;
			else if (addr[3:2] == 2'h0)
				chan_mask = 4'h1 << addr[1:0];
			else
				chan_mask = 4'h0;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////////
	// Frame shifter and state.
	reg [1:0]  state_r;
	reg [31:0] shift_r;
	reg [5:0]  count_r;
	reg [1:0]  por_cnt_r;
	reg [15:0] input_r [0:3];
	reg [15:0] dac_r [0:3];
	reg [1:0]  pmode_r [0:3];
	reg [1:0]  clear_sel_r;
	reg [3:0]  override_r;
	reg        cleared_r;
	reg [3:0]  wr_mask;
	reg [3:0]  upd_mask;
	reg [15:0] por_code;
	reg [31:0] frame;
	// Command strobes decoded in the frame's last cycle.
	reg        pwr_cmd;
	reg        csel_cmd;
	reg        ovr_cmd;
	reg        srst_cmd;
	integer    i;
	integer    j;

	wire [31:0] frame_nxt  = {shift_r[30:0], din_lvl};
	// Pulses past the 32nd are ignored: the frame has already gone back to idle.
	wire        last_edge  = (state_r == ST_RUN) && sclk_fall && !sync_lvl
	                         && (count_r == `FRAME_BITS - 6'h1);
	wire [3:0]  cmd        = frame_nxt[`CMD_MSB:`CMD_MSB-3];
	wire [3:0]  addr       = frame_nxt[`ADDR_MSB:`ADDR_MSB-3];
	wire [15:0] data       = frame_nxt[`DATA_MSB:`DATA_MSB-15];
	// A set override bit makes its channel behave as if the strobe were held low.
	wire [3:0]  hw_upd     = load_update_strobe_n_lvl ? override_r : 4'hF;

	always @* begin
		por_code = por_lvl ? `CODE_MID : `CODE_ZERO;
		frame    = frame_nxt;
		wr_mask  = 4'h0;
		upd_mask = 4'h0;
		pwr_cmd  = 1'b0;
		csel_cmd = 1'b0;
		ovr_cmd  = 1'b0;
		srst_cmd = 1'b0;
		if (last_edge) begin
			case (cmd)
				`CMD_WR_INPUT: begin
					wr_mask  = chan_mask(addr);
					upd_mask = chan_mask(addr) & hw_upd;
				end
				`CMD_UPD_DAC:    upd_mask = chan_mask(addr);
				`CMD_WR_UPD_ALL: begin
					wr_mask  = chan_mask(addr);
					upd_mask = 4'hF;
				end
				`CMD_WR_UPD_ONE: begin
					wr_mask  = chan_mask(addr);
					upd_mask = chan_mask(addr);
				end
				`CMD_POWER:      pwr_cmd  = 1'b1;
				`CMD_CLEAR_CODE: csel_cmd = 1'b1;
				`CMD_OVERRIDE:   ovr_cmd  = 1'b1;
				`CMD_SOFT_RESET: srst_cmd = 1'b1;
				default: begin
					wr_mask  = 4'h0;
					upd_mask = 4'h0;
				end
			endcase
		end
		// A strobe edge in a frame's final cycle is served together with the frame.
		if (load_update_strobe_n_fall)
			upd_mask = 4'hF;
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r     <= ST_POR;
			shift_r     <= 32'h0000_0000;
			count_r     <= 6'h00;
			por_cnt_r   <= 2'h0;
			clear_sel_r <= `CLEAR_SEL_RESET;
			override_r  <= `OVERRIDE_RESET;
			cleared_r   <= 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				input_r[i] <= 16'h0000;
				dac_r[i]   <= 16'h0000;
				pmode_r[i] <= `PWR_NORMAL;
			end
		end else begin
			case (state_r)
				ST_POR: begin
					// The select pin needs two cycles to cross its synchroniser, so the
					// codes are loaded again until the settled level has been taken.
					for (i = 0; i < 4; i = i + 1) begin
						input_r[i] <= por_code;
						dac_r[i]   <= por_code;
					end
					if (por_cnt_r == `POR_WAIT)
						state_r <= ST_IDLE;
					else
						por_cnt_r <= por_cnt_r + 2'h1;
				end
				ST_IDLE: begin
					// A frame opens only on a fresh falling edge of frame sync.
					if (sync_fall) begin
						state_r <= ST_RUN;
						count_r <= 6'h00;
					end
				end
				ST_RUN: begin
					// A void or aborted frame just returns to idle with nothing executed.
					if (sync_rise || clr_fall) begin
						state_r <= ST_IDLE;
					end else if (sclk_fall) begin
						shift_r <= frame_nxt;
						count_r <= count_r + 6'h01;
						if (last_edge)
							state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase

			if (state_r != ST_POR) begin
				// A clear outranks a frame end in the same cycle, so that frame is lost.
				if (clr_fall) begin
					cleared_r <= 1'b1;
					if (clear_sel_r != 2'h3) begin
						for (i = 0; i < 4; i = i + 1) begin
							input_r[i] <= clear_code(clear_sel_r);
							dac_r[i]   <= clear_code(clear_sel_r);
						end
					end
				end else if (last_edge || load_update_strobe_n_fall) begin
					// Write mask and command strobes are already gated by the frame end; the update mask also by the strobe edge.
					if (last_edge)
						cleared_r <= 1'b0;
					for (i = 0; i < 4; i = i + 1) begin
						if (wr_mask[i])
							input_r[i] <= data;
						if (upd_mask[i])
							dac_r[i] <= wr_mask[i] ? data : input_r[i];
						if (pwr_cmd && frame[i])
							pmode_r[i] <= frame[`PWR_MODE_MSB:`PWR_MODE_MSB-1];
						if (srst_cmd) begin
							input_r[i] <= por_code;
							dac_r[i]   <= por_code;
						end
					end
					if (csel_cmd)
						clear_sel_r <= frame[1:0];
					if (ovr_cmd)
						override_r <= frame[3:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Output stage control.
	// Switch controls are registered so that the output stage never sees decode glitches.
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			amp_connect  <= 4'hF;
			load_1k_en   <= 4'h0;
			load_100k_en <= 4'h0;
		end else begin
			for (j = 0; j < 4; j = j + 1) begin
				amp_connect[j]  <= (pmode_r[j] == `PWR_NORMAL);
				load_1k_en[j]   <= (pmode_r[j] == `PWR_1K);
				load_100k_en[j] <= (pmode_r[j] == `PWR_100K);
			end
		end
	end

	assign dac_code_a   = dac_r[0];
	assign dac_code_b   = dac_r[1];
	assign dac_code_c   = dac_r[2];
	assign dac_code_d   = dac_r[3];
	assign power_mode   = {pmode_r[3], pmode_r[2], pmode_r[1], pmode_r[0]};
	assign clear_active = cleared_r;
	// Busy only while the power-up code is still being taken in.
	assign por_busy     = (state_r == ST_POR);
endmodule // quad_dac_control_logic

// *** tb/quad_dac_chk.sv ***
// Port assertions of the quad converter control logic.
`timescale 1ns/1ns
module quad_dac_chk (
	input wire        clk_sys,
	input wire        resetn,
	input wire        por_level_sel,
	input wire        frame_sync_n,
	input wire        load_update_strobe_n,
	input wire        clear_strobe_n,
	input wire [15:0] dac_code_a,
	input wire [15:0] dac_code_d,
	input wire [7:0]  power_mode,
	input wire [3:0]  amp_connect,
	input wire [3:0]  load_1k_en,
	input wire [3:0]  load_100k_en,
	input wire        clear_active,
	input wire        por_busy
);
	reg [3:0] quiet_r;
	// Counts idle cycles of every pin that can start a change, so that pipeline lag is covered.
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			quiet_r <= 4'h0;
		else if (!(frame_sync_n && load_update_strobe_n && clear_strobe_n))
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hF)
			quiet_r <= quiet_r + 4'h1;
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_amp_normal_a: assert property ($stable(power_mode)[*2] |->
		amp_connect[0] == (power_mode[1:0] == 2'h0)) else $error("amp A decode");
	a_load_1k_a: assert property ($stable(power_mode)[*2] |->
		load_1k_en[0] == (power_mode[1:0] == 2'h1)) else $error("1k A decode");
	a_load_100k_d: assert property ($stable(power_mode)[*2] |->
		load_100k_en[3] == (power_mode[7:6] == 2'h2)) else $error("100k D decode");
	a_clear_marks: assert property ($fell(clear_strobe_n) && !por_busy |->
		##[1:8] clear_active) else $error("clear not marked");
	a_idle_hold: assert property (quiet_r >= 4'h8 |-> $stable(dac_code_a) &&
		$stable(dac_code_d) && $stable(power_mode)) else $error("state moved idle");
	a_por_code: assert property (por_busy |-> ##[1:4]
		dac_code_a == {por_level_sel, 15'h0000}) else $error("power-up code");
	a_clear_exit: assert property ($fell(clear_active) |->
		!$past(frame_sync_n, 3)) else $error("clear left outside frame");
	a_mode_in_frame: assert property ($changed(power_mode) |->
		!$past(frame_sync_n, 3)) else $error("mode changed outside frame");
endmodule // quad_dac_chk

// *** tb/serial_host.sv ***
// Serial host model driving write frames onto the converter pins.
`timescale 1ns/1ns
module serial_host (
	input  wire clk_sys,
	output reg  frame_sync_n,
	output reg  shift_clk,
	output reg  serial_data
);
	initial begin
		frame_sync_n = 1'b1;
		shift_clk = 1'b1;
		serial_data = 1'b0;
	end
	// Sends the top nbits of word; fewer than 32 voids the frame. Shift clock idles high.
	task send(input [31:0] word, input integer nbits);
		integer i;
		begin
			@(posedge clk_sys) frame_sync_n <= 1'b0;
			repeat (8) @(posedge clk_sys);
			for (i = 31; i > 31 - nbits; i = i - 1) begin
				serial_data <= word[i];
				repeat (8) @(posedge clk_sys);
				shift_clk <= 1'b0;
				repeat (8) @(posedge clk_sys);
				shift_clk <= 1'b1;
			end
			repeat (8) @(posedge clk_sys);
			frame_sync_n <= 1'b1;
			serial_data <= ~serial_data;
			repeat (8) @(posedge clk_sys);
		end
	endtask
endmodule // serial_host

// *** tb/tb_quad_dac_control_logic.sv ***
// Self-checking bench of the quad converter control logic.
`timescale 1ns/1ns
`include "quad_dac_regs.vh"
module tb_quad_dac_control_logic;
	reg         clk_sys = 1'b0;
	reg         resetn = 1'b0;
	reg         por_sel = 1'b1;
	reg         load_n = 1'b1;
	reg         clr_n = 1'b1;
	wire        sync_n, sclk, sdata, clear_active;
	wire [15:0] code_a, code_b, code_c, code_d;
	wire [7:0]  pm;
	integer     mismatches = 0;
	integer     comparisons = 0;
	integer     cycles = 0;
	quad_dac_control_logic i_dut (.clk_sys(clk_sys), .resetn(resetn), .por_level_sel(por_sel),
		.frame_sync_n(sync_n), .shift_clk(sclk), .serial_data(sdata),
		.load_update_strobe_n(load_n), .clear_strobe_n(clr_n), .dac_code_a(code_a),
		.dac_code_b(code_b), .dac_code_c(code_c), .dac_code_d(code_d), .power_mode(pm),
		.amp_connect(), .load_1k_en(), .load_100k_en(), .clear_active(clear_active),
		.por_busy());
	serial_host i_host (.clk_sys(clk_sys), .frame_sync_n(sync_n), .shift_clk(sclk),
		.serial_data(sdata));
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			mismatches = mismatches + 1;
			finish_test;
		end
	end
	////////////////////////////////////////////////////////////
	task finish_test;
		begin
			$display("Counts: %0d compared, %0d mismatches", comparisons, mismatches);
			if (mismatches == 0 && comparisons > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input string name, input [15:0] exp, input [15:0] got);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("MISMATCH %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task codes(input [15:0] a, input [15:0] b, input [15:0] c, input [15:0] d);
		begin
			chk("code_a", a, code_a);
			chk("code_b", b, code_b);
			chk("code_c", c, code_c);
			chk("code_d", d, code_d);
		end
	endtask
	task wr(input [3:0] cmd, input [3:0] addr, input [19:0] low);
		i_host.send({4'h0, cmd, addr, low}, 32);
	endtask
	task pulse_clr;
		begin
			@(posedge clk_sys) clr_n <= 1'b0;
			repeat (8) @(posedge clk_sys);
			clr_n <= 1'b1;
			repeat (8) @(posedge clk_sys);
		end
	endtask
	////////////////////////////////////////////////////////////
	task t_reset(input sel, input [15:0] exp);
		begin
			@(posedge clk_sys) resetn <= 1'b0;
			por_sel <= sel;
			repeat (10) @(posedge clk_sys);
			resetn <= 1'b1;
			repeat (6) @(posedge clk_sys);
			codes(exp, exp, exp, exp);
			i_host.send({8'h03, 4'h0, 16'h1234, 4'h0}, 20);
			codes(exp, exp, exp, exp);
			$display("test reset done");
		end
	endtask
	task t_update;
		begin
			wr(`CMD_WR_INPUT, 4'h0, 20'h11110);
			chk("async a", 16'h8000, code_a);
			@(posedge clk_sys) load_n <= 1'b0;
			repeat (8) @(posedge clk_sys);
			load_n <= 1'b1;
			repeat (8) @(posedge clk_sys);
			chk("pulse a", 16'h1111, code_a);
			wr(`CMD_WR_UPD_ALL, 4'h1, 20'h22220);
			codes(16'h1111, 16'h2222, 16'h8000, 16'h8000);
			@(posedge clk_sys) load_n <= 1'b0;
			wr(`CMD_WR_INPUT, 4'h2, 20'h33330);
			load_n <= 1'b1;
			chk("sync c", 16'h3333, code_c);
			wr(`CMD_OVERRIDE, 4'h0, 20'h00008);
			wr(`CMD_WR_INPUT, `ADDR_ALL, 20'h44440);
			codes(16'h1111, 16'h2222, 16'h3333, 16'h4444);
			wr(`CMD_OVERRIDE, 4'h0, 20'h00000);
			wr(`CMD_UPD_DAC, 4'h1, 20'h00000);
			codes(16'h1111, 16'h4444, 16'h3333, 16'h4444);
			$display("test update done");
		end
	endtask
	task t_power;
		begin
			wr(`CMD_POWER, 4'h0, 20'h00205);
			chk("mode", 16'h0022, {8'h00, pm});
			wr(`CMD_POWER, 4'h0, 20'h00102);
			chk("mode", 16'h0026, {8'h00, pm});
			wr(`CMD_POWER, 4'h0, 20'h00308);
			chk("mode", 16'h00E6, {8'h00, pm});
			wr(`CMD_WR_UPD_ONE, 4'h0, 20'h55550);
			codes(16'h5555, 16'h4444, 16'h3333, 16'h4444);
			wr(`CMD_POWER, 4'h0, 20'h0000F);
			chk("mode", 16'h0000, {8'h00, pm});
			$display("test power done");
		end
	endtask
	task t_clear;
		begin
			pulse_clr;
			codes(16'h0000, 16'h0000, 16'h0000, 16'h0000);
			chk("clr act", 16'h0001, {15'h0000, clear_active});
			wr(`CMD_CLEAR_CODE, 4'h0, 20'h00002);
			chk("clr act", 16'h0000, {15'h0000, clear_active});
			pulse_clr;
			@(posedge clk_sys) load_n <= 1'b0;
			repeat (8) @(posedge clk_sys);
			load_n <= 1'b1;
			repeat (8) @(posedge clk_sys);
			codes(16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF);
			wr(`CMD_CLEAR_CODE, 4'h0, 20'h00001);
			pulse_clr;
			codes(16'h8000, 16'h8000, 16'h8000, 16'h8000);
			wr(`CMD_CLEAR_CODE, 4'h0, 20'h00003);
			wr(`CMD_WR_UPD_ONE, 4'h0, 20'h01010);
			pulse_clr;
			chk("noop a", 16'h0101, code_a);
			fork
				wr(`CMD_WR_UPD_ONE, 4'h0, 20'h77770);
				begin
					repeat (200) @(posedge clk_sys);
					pulse_clr;
				end
			join
			chk("abort a", 16'h0101, code_a);
			wr(`CMD_SOFT_RESET, 4'h0, 20'h00000);
			codes(16'h8000, 16'h8000, 16'h8000, 16'h8000);
			$display("test clear done");
		end
	endtask
	initial begin
		t_reset(1'b1, 16'h8000);
		t_update;
		t_power;
		t_clear;
		t_reset(1'b0, 16'h0000);
		finish_test;
	end
endmodule // tb_quad_dac_control_logic
bind quad_dac_control_logic quad_dac_chk i_chk (.clk_sys(clk_sys), .resetn(resetn),
	.por_level_sel(por_level_sel), .frame_sync_n(frame_sync_n),
	.load_update_strobe_n(load_update_strobe_n), .clear_strobe_n(clear_strobe_n),
	.dac_code_a(dac_code_a), .dac_code_d(dac_code_d), .power_mode(power_mode),
	.amp_connect(amp_connect), .load_1k_en(load_1k_en), .load_100k_en(load_100k_en),
	.clear_active(clear_active), .por_busy(por_busy));
